/* File: hw/dmst_cfg.svh */
// constants for the drive mode, security and trip parameter block
`ifndef DMST_CFG_SVH
`define DMST_CFG_SVH
// parameter selectors on the access port
`define DMST_SEL_MODE    3'h0
`define DMST_SEL_SEC     3'h1
`define DMST_SEL_VER     3'h2
`define DMST_SEL_TRIP    3'h3
`define DMST_SEL_UNLOCK  3'h4
`define DMST_SEL_RSTCMD  3'h5
`define DMST_SEL_KPACC   3'h6
// unlock keys and reset command value
`define DMST_KEY_EUR     16'h04e5
`define DMST_KEY_USA     16'h04e6
`define DMST_RST_CMD     16'h0064
// value ranges
`define DMST_MODE_MIN    16'h0001
`define DMST_MODE_MAX    16'h0004
`define DMST_SEC_MAX     16'h0002
`define DMST_TRIP_MAX    16'h000f
// security levels
`define DMST_SEC_MENU0   2'h0
`define DMST_SEC_ALL     2'h1
`define DMST_SEC_LOCK    2'h2
// trip response bit positions
`define DMST_TB_STOP     0
`define DMST_TB_BRAKE    1
`define DMST_TB_PHASE    2
`define DMST_TB_BRES     3
// reset values
`define DMST_ZERO16      16'h0000
`define DMST_TRIP_RST    4'h0
`define DMST_FW_VER      16'h0064
`endif

/* File: hw/dmst_pkg.sv */
// types for the drive mode, security and trip parameter block
package dmst_pkg;
    // numeric mode codes, also the serial values
    typedef enum logic [2:0] {
        DMST_OPEN_LOOP     = 3'h1,
        DMST_CLOSED_VECTOR = 3'h2,
        DMST_SERVO         = 3'h3,
        DMST_REGEN         = 3'h4
    } dmst_mode_t;
    // trip sequencer states
    typedef enum logic [1:0] {
        DMST_TS_IDLE  = 2'h0,
        DMST_TS_STOP  = 2'h1,
        DMST_TS_TRIP  = 2'h2
    } dmst_trip_t;
endpackage

/* File: hw/dmst_params.sv */
// drive mode, keypad security, version and trip response parameter logic
`include "dmst_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dmst_params #(
    parameter logic [15:0] FW_VERSION = `DMST_FW_VER  // arbitrary value, hundredths
) (
    input  wire logic                CORE_CLK_I,
    input  wire logic                RST_I,
    input  wire logic                PAR_WR_I,
    input  wire logic                PAR_SRC_SERIAL_I,
    input  wire logic [2:0]          PAR_SEL_I,
    input  wire logic [15:0]         PAR_WDATA_I,
    output logic      [15:0]         PAR_RDATA_O,
    output logic                     PAR_ERR_O,
    input  wire logic                RESET_BTN_I,
    input  wire logic                RESET_DIN_I,
    input  wire logic [5:0]          NI_TRIP_I,
    input  wire logic                BRAKE_TRIP_I,
    input  wire logic                PHASE_LOSS_I,
    input  wire logic                BRES_FAIL_I,
    input  wire logic                FRAME_SIZE0_I,
    input  wire logic                MOTOR_STOPPED_I,
    output dmst_pkg::dmst_mode_t     ACTIVE_MODE_O,
    output logic                     REGION_USA_O,
    output logic                     MENU_ALL_O,
    output logic                     USER_LOCK_O,
    output logic                     DRIVE_RESET_O,
    output logic                     DEFAULTS_LOAD_O,
    output logic                     MOTOR_DEF_O,
    output logic                     NVM_SAVE_O,
    output logic                     STOP_REQ_O,
    output logic                     TRIP_O
);
    import dmst_pkg::*;

    // ****************************************
    // helper functions
    // ****************************************
    // true when the unlock key holds a defaults key
    function automatic logic key_ok(input logic [15:0] k);
        key_ok = (k == `DMST_KEY_EUR) || (k == `DMST_KEY_USA);
    endfunction

    // true when a written value is a legal mode code
    function automatic logic mode_ok(input logic [15:0] v);
        mode_ok = (v >= `DMST_MODE_MIN) && (v <= `DMST_MODE_MAX);
    endfunction

    // ****************************************
    // state
    // ****************************************
    dmst_mode_t  active_mode_r;
    dmst_mode_t  pending_mode_r;
    logic        region_usa_r;
    logic [15:0] unlock_r;
    logic [1:0]  sec_r;
    logic        user_lock_r;
    logic [3:0]  trip_bits_r;
    logic [15:0] rst_cmd_r;
    logic [15:0] kp_acc_r;
    logic [15:0] rdata_r;
    logic        err_r;
    logic [2:0]  btn_sync_r, din_sync_r;
    logic        btn_lvl_r, din_lvl_r;
    logic        drv_rst_r;
    logic        def_load_r, nvm_save_r;
    logic        menu_all_r;
    dmst_trip_t  trip_st_r;
    dmst_trip_t  trip_nxt;
    logic        stop_req_r, trip_r;
    logic        wr_ok, keypad_ok, ser_rst;
    logic        btn_agree, din_agree;
    logic        drv_req, mode_chg;
    logic        hard_trip, soft_trip;

    // ****************************************
    // write acceptance
    // ****************************************
    // a locked keypad may only touch the security level
    assign keypad_ok = PAR_SRC_SERIAL_I || !user_lock_r;
    // decide whether the write on the port this cycle is taken
    always_comb begin
        wr_ok = 1'b0;
        if (PAR_WR_I && !drv_rst_r) begin
            case (PAR_SEL_I)
                `DMST_SEL_MODE:   wr_ok = keypad_ok && key_ok(unlock_r) && mode_ok(PAR_WDATA_I);
                `DMST_SEL_SEC:    wr_ok = (PAR_WDATA_I <= `DMST_SEC_MAX);
                `DMST_SEL_VER:    wr_ok = 1'b0;
                `DMST_SEL_TRIP:   wr_ok = keypad_ok && (PAR_WDATA_I <= `DMST_TRIP_MAX);
                `DMST_SEL_UNLOCK: wr_ok = keypad_ok;
                `DMST_SEL_RSTCMD: wr_ok = keypad_ok;
                `DMST_SEL_KPACC:  wr_ok = keypad_ok;
                default:          wr_ok = 1'b0;
            endcase
        end
    end

    // refused writes raise a one-cycle error pulse
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            err_r <= 1'b0;
        end else begin
            err_r <= PAR_WR_I && !wr_ok;
        end
    end

    // ****************************************
    // drive reset sources
    // ****************************************
    // pins pass three flops; the first is read only by the second
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            btn_sync_r <= 3'h0;
            din_sync_r <= 3'h0;
        end else begin
            btn_sync_r <= {btn_sync_r[1:0], RESET_BTN_I};
            din_sync_r <= {din_sync_r[1:0], RESET_DIN_I};
        end
    end

    // a level counts once stages two and three agree
    assign btn_agree = (btn_sync_r[1] == btn_sync_r[2]);
    assign din_agree = (din_sync_r[1] == din_sync_r[2]);
    // filtered levels of the reset button and reset input
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            btn_lvl_r <= 1'b0;
            din_lvl_r <= 1'b0;
        end else begin
            if (btn_agree) btn_lvl_r <= btn_sync_r[2];
            if (din_agree) din_lvl_r <= din_sync_r[2];
        end
    end

    // only a serial host may fire a reset through the command value
    assign ser_rst = wr_ok && PAR_SRC_SERIAL_I && (PAR_SEL_I == `DMST_SEL_RSTCMD)
                     && (PAR_WDATA_I == `DMST_RST_CMD);

    // button press, any input toggle, or serial command
    assign drv_req = (btn_agree && btn_sync_r[2] && !btn_lvl_r)
                     || (din_agree && (din_sync_r[2] != din_lvl_r))
                     || ser_rst;

    // register the reset event so all its effects share one edge
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            drv_rst_r <= 1'b0;
        end else begin
            drv_rst_r <= drv_req;
        end
    end

    // a mode change is applied only by a drive reset
    assign mode_chg = drv_rst_r && (pending_mode_r != active_mode_r);

    // ****************************************
    // operating mode
    // ****************************************
    // pending value is held apart so the running mode stays put
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            pending_mode_r <= DMST_OPEN_LOOP;
            active_mode_r  <= DMST_OPEN_LOOP;
        end else begin
            if (mode_chg) begin
                active_mode_r <= pending_mode_r;
            end else if (wr_ok && PAR_SEL_I == `DMST_SEL_MODE) begin
                pending_mode_r <= dmst_mode_t'(PAR_WDATA_I[2:0]);
            end
        end
    end

    // defaults region follows the key present at the change
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            region_usa_r <= 1'b0;
        end else if (mode_chg) begin
            region_usa_r <= (unlock_r == `DMST_KEY_USA);
        end
    end

    // default load, motor data reset and save all pulse together
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            def_load_r <= 1'b0;
            nvm_save_r <= 1'b0;
        end else begin
            def_load_r <= mode_chg;
            nvm_save_r <= mode_chg;
        end
    end

    // ****************************************
    // unlock key and reset command
    // ****************************************
    // key clears after the reset that applies a mode change
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            unlock_r <= `DMST_ZERO16;
        end else if (mode_chg) begin
            unlock_r <= `DMST_ZERO16;
        end else if (wr_ok && PAR_SEL_I == `DMST_SEL_UNLOCK) begin
            unlock_r <= PAR_WDATA_I;
        end
    end

    // command value reads back until the reset consumes it
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            rst_cmd_r <= `DMST_ZERO16;
        end else if (drv_rst_r) begin
            rst_cmd_r <= `DMST_ZERO16;
        end else if (wr_ok && PAR_SEL_I == `DMST_SEL_RSTCMD) begin
            rst_cmd_r <= PAR_WDATA_I;
        end
    end

    // ****************************************
    // keypad security
    // ****************************************
    // level 2 arms a lock that the next drive reset applies
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            sec_r       <= `DMST_SEC_MENU0;
            user_lock_r <= 1'b0;
        end else if (drv_rst_r) begin
            if (sec_r == `DMST_SEC_LOCK) begin
                user_lock_r <= 1'b1;
                sec_r       <= `DMST_SEC_MENU0;
            end
        end else if (wr_ok && PAR_SEL_I == `DMST_SEL_SEC) begin
            sec_r <= PAR_WDATA_I[1:0];
        end
    end

    // menu reach follows the level; the default load leaves it alone
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            menu_all_r <= 1'b0;
        end else begin
            menu_all_r <= (sec_r == `DMST_SEC_ALL);
        end
    end

    // keypad access value survives the default load
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            kp_acc_r <= `DMST_ZERO16;
        end else if (wr_ok && PAR_SEL_I == `DMST_SEL_KPACC) begin
            kp_acc_r <= PAR_WDATA_I;
        end
    end

    // ****************************************
    // trip response
    // ****************************************
    // trip bits go back to their default on a mode change
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            trip_bits_r <= `DMST_TRIP_RST;
        end else if (mode_chg) begin
            trip_bits_r <= `DMST_TRIP_RST;
        end else if (wr_ok && PAR_SEL_I == `DMST_SEL_TRIP) begin
            trip_bits_r <= PAR_WDATA_I[3:0];
        end
    end

    // trips that never wait for a stop
    assign hard_trip = (BRAKE_TRIP_I && !trip_bits_r[`DMST_TB_BRAKE])
                       || (PHASE_LOSS_I && !(FRAME_SIZE0_I && trip_bits_r[`DMST_TB_PHASE]))
                       || (BRES_FAIL_I && !(FRAME_SIZE0_I && trip_bits_r[`DMST_TB_BRES]));

    // any of the six non-important classes
    assign soft_trip = |NI_TRIP_I;
    // next trip state; a drive reset clears a latched trip
    always_comb begin
        trip_nxt = trip_st_r;
        case (trip_st_r)
            DMST_TS_IDLE: begin
                if (hard_trip) begin
                    trip_nxt = DMST_TS_TRIP;
                end else if (soft_trip && trip_bits_r[`DMST_TB_STOP] && active_mode_r != DMST_REGEN) begin
                    trip_nxt = DMST_TS_STOP;
                end else if (soft_trip) begin
                    trip_nxt = DMST_TS_TRIP;
                end
            end
            // a hard trip must not wait behind the ramp down
            DMST_TS_STOP: trip_nxt = (hard_trip || MOTOR_STOPPED_I) ? DMST_TS_TRIP : DMST_TS_STOP;
            DMST_TS_TRIP: trip_nxt = drv_rst_r ? DMST_TS_IDLE : DMST_TS_TRIP;
            default:      trip_nxt = DMST_TS_IDLE;
        endcase
    end

    // trip state with registered stop and trip outputs
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            trip_st_r  <= DMST_TS_IDLE;
            stop_req_r <= 1'b0;
            trip_r     <= 1'b0;
        end else begin
            trip_st_r  <= trip_nxt;
            stop_req_r <= (trip_nxt == DMST_TS_STOP);
            trip_r     <= (trip_nxt == DMST_TS_TRIP);
        end
    end

    // ****************************************
    // read back
    // ****************************************
    // mode reads as its numeric serial code; text is the keypad's job
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            rdata_r <= `DMST_ZERO16;
        end else begin
            case (PAR_SEL_I)
                `DMST_SEL_MODE:   rdata_r <= {13'h0000, pending_mode_r};
                `DMST_SEL_SEC:    rdata_r <= {14'h0000, sec_r};
                `DMST_SEL_VER:    rdata_r <= FW_VERSION;
                `DMST_SEL_TRIP:   rdata_r <= {12'h000, trip_bits_r};
                `DMST_SEL_UNLOCK: rdata_r <= unlock_r;
                `DMST_SEL_RSTCMD: rdata_r <= rst_cmd_r;
                `DMST_SEL_KPACC:  rdata_r <= kp_acc_r;
                default:          rdata_r <= `DMST_ZERO16;
            endcase
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign PAR_RDATA_O     = rdata_r;
    assign PAR_ERR_O       = err_r;
    assign ACTIVE_MODE_O   = active_mode_r;
    assign REGION_USA_O    = region_usa_r;
    assign MENU_ALL_O      = menu_all_r;
    assign USER_LOCK_O     = user_lock_r;
    assign DRIVE_RESET_O   = drv_rst_r;
    assign DEFAULTS_LOAD_O = def_load_r;
    assign MOTOR_DEF_O     = def_load_r;
    assign NVM_SAVE_O      = nvm_save_r;
    assign STOP_REQ_O      = stop_req_r;
    assign TRIP_O          = trip_r;
endmodule

`default_nettype wire

/* File: dv/dmst_params_chk.sv */
// concurrent checks on the ports of the drive mode, security and trip parameter block
`include "dmst_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dmst_params_chk (
    input wire logic                 CORE_CLK_I,
    input wire logic                 RST_I,
    input wire logic                 PAR_WR_I,
    input wire logic                 PAR_SRC_SERIAL_I,
    input wire logic [2:0]           PAR_SEL_I,
    input wire logic [15:0]          PAR_WDATA_I,
    input wire logic                 PAR_ERR_O,
    input wire dmst_pkg::dmst_mode_t ACTIVE_MODE_O,
    input wire logic                 MENU_ALL_O,
    input wire logic                 USER_LOCK_O,
    input wire logic                 DRIVE_RESET_O,
    input wire logic                 DEFAULTS_LOAD_O,
    input wire logic                 MOTOR_DEF_O,
    input wire logic                 NVM_SAVE_O,
    input wire logic                 TRIP_O
);
    import dmst_pkg::*;
    // ****************************************************
    // clocking and step sequences
    // ****************************************************
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    // serial reset command that the port is free to take
    sequence s_serial_rst;
        PAR_WR_I && PAR_SRC_SERIAL_I && PAR_SEL_I == `DMST_SEL_RSTCMD && PAR_WDATA_I == `DMST_RST_CMD && !DRIVE_RESET_O;
    endsequence
    // security level 1 written outside the reset cycle; keypad is allowed even when locked
    sequence s_sec_all;
        PAR_WR_I && PAR_SEL_I == `DMST_SEL_SEC && PAR_WDATA_I == 16'h0001 && !DRIVE_RESET_O;
    endsequence
    // ****************************************************
    // assertions
    // ****************************************************
    mode_range_a: assert property (ACTIVE_MODE_O inside {[3'h1:3'h4]})
        else $error("active mode outside 1 to 4");
    load_after_reset_a: assert property (DEFAULTS_LOAD_O |-> $past(DRIVE_RESET_O))
        else $error("default load without a drive reset before it");
    load_together_a: assert property (DEFAULTS_LOAD_O == MOTOR_DEF_O && DEFAULTS_LOAD_O == NVM_SAVE_O)
        else $error("default load, motor defaults and save not in one cycle");
    mode_hold_a: assert property (!DRIVE_RESET_O |=> $stable(ACTIVE_MODE_O))
        else $error("active mode moved without a drive reset");
    menu_all_a: assert property (s_sec_all |-> ##[1:2] MENU_ALL_O)
        else $error("security 1 did not open all menus");
    lock_on_reset_a: assert property ($rose(USER_LOCK_O) |-> $past(DRIVE_RESET_O))
        else $error("user lock set outside a drive reset");
    version_ro_a: assert property (PAR_WR_I && PAR_SEL_I == `DMST_SEL_VER |=> PAR_ERR_O)
        else $error("version write not refused");
    trip_hold_a: assert property (TRIP_O && !DRIVE_RESET_O |=> TRIP_O)
        else $error("trip dropped without a drive reset");
    serial_reset_a: assert property (s_serial_rst |=> DRIVE_RESET_O)
        else $error("serial reset command gave no drive reset");
endmodule
bind dmst_params dmst_params_chk i_dmst_params_chk (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .PAR_WR_I(PAR_WR_I),
    .PAR_SRC_SERIAL_I(PAR_SRC_SERIAL_I), .PAR_SEL_I(PAR_SEL_I), .PAR_WDATA_I(PAR_WDATA_I), .PAR_ERR_O(PAR_ERR_O),
    .ACTIVE_MODE_O(ACTIVE_MODE_O), .MENU_ALL_O(MENU_ALL_O), .USER_LOCK_O(USER_LOCK_O),
    .DRIVE_RESET_O(DRIVE_RESET_O), .DEFAULTS_LOAD_O(DEFAULTS_LOAD_O), .MOTOR_DEF_O(MOTOR_DEF_O),
    .NVM_SAVE_O(NVM_SAVE_O), .TRIP_O(TRIP_O));
`default_nettype wire

/* File: dv/dmst_operator_model.sv */
// operator model: reset button, reset input and a motor that coasts to rest
`timescale 1ns/1ps
`default_nettype none
module dmst_operator_model (
    input  wire logic clk_i,
    input  wire logic press_i,
    input  wire logic toggle_i,
    input  wire logic stop_req_i,
    output logic      btn_o,
    output logic      din_o,
    output logic      stopped_o
);
    logic [2:0] btn_cnt_r = 3'h0;
    logic [1:0] stop_cnt_r = 2'h0;
    logic       din_r      = 1'b0;
    logic       stopped_r  = 1'b0;
    // button held five cycles so the pin filter never sees a glitch
    always_ff @(posedge clk_i) begin
        btn_cnt_r <= press_i ? 3'h5 : (btn_cnt_r != 3'h0 ? btn_cnt_r - 3'h1 : 3'h0);
    end
    assign btn_o = (btn_cnt_r != 3'h0);
    // reset input is a level that only ever toggles
    always_ff @(posedge clk_i) begin
        din_r <= toggle_i ? ~din_r : din_r;
    end
    assign din_o = din_r;
    // enable, reference and run commands stay with the operator, outside this block
    // motor takes four cycles to stop; no longer stopped once the request goes
    always_ff @(posedge clk_i) begin
        stop_cnt_r <= stop_req_i ? (stop_cnt_r != 2'h3 ? stop_cnt_r + 2'h1 : 2'h3) : 2'h0;
        stopped_r <= stop_req_i && stop_cnt_r == 2'h3;
    end
    assign stopped_o = stopped_r;
endmodule
`default_nettype wire

/* File: dv/dmst_params_test.sv */
// self-checking testbench of the drive mode, security and trip parameter block
`include "dmst_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dmst_params_test;
    import dmst_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr = 1'b0;
    logic        ser = 1'b0;
    logic [2:0]  sel = 3'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic        err;
    logic [5:0]  ni = 6'h00;
    logic [3:0]  src = 4'h0;
    logic        frame0 = 1'b0;
    logic        press = 1'b0;
    logic        toggle = 1'b0;
    logic        btn, din, stopped, region, menu, lock, drst, dload, stop, trip, mdef, nsave;
    dmst_mode_t  mode;
    int          failures = 0;
    int          checks_done = 0;
    always #5 clk = ~clk;
    dmst_params i_dmst_params (.CORE_CLK_I(clk), .RST_I(rst), .PAR_WR_I(wr), .PAR_SRC_SERIAL_I(ser),
        .PAR_SEL_I(sel), .PAR_WDATA_I(wdata), .PAR_RDATA_O(rdata), .PAR_ERR_O(err), .RESET_BTN_I(btn),
        .RESET_DIN_I(din), .NI_TRIP_I(ni), .BRAKE_TRIP_I(src[0]), .PHASE_LOSS_I(src[1]), .BRES_FAIL_I(src[2]),
        .FRAME_SIZE0_I(frame0), .MOTOR_STOPPED_I(stopped), .ACTIVE_MODE_O(mode), .REGION_USA_O(region),
        .MENU_ALL_O(menu), .USER_LOCK_O(lock), .DRIVE_RESET_O(drst), .DEFAULTS_LOAD_O(dload), .MOTOR_DEF_O(mdef),
        .NVM_SAVE_O(nsave), .STOP_REQ_O(stop), .TRIP_O(trip));
    dmst_operator_model i_dmst_operator_model (.clk_i(clk), .press_i(press), .toggle_i(toggle),
        .stop_req_i(stop), .btn_o(btn), .din_o(din), .stopped_o(stopped));
    // ****************************************************
    // access and compare tasks; all start and end 1 ns after an edge
    // ****************************************************
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_par(input logic [2:0] s, input logic [15:0] d, input logic sr, input logic e);
        // idle edge first, so back-to-back writes never drop and raise the strobe in one step
        step(1);
        wr = 1'b1;
        sel = s;
        wdata = d;
        ser = sr;
        step(1);
        wr = 1'b0;
        chk("write refusal", {15'h0, e}, {15'h0, err});
    endtask
    task automatic rd_par(input logic [2:0] s, input logic [15:0] e);
        sel = s;
        step(1);
        chk("read data", e, rdata);
    endtask
    // bounded wait for the drive reset pulse, returns in the cycle after it
    task automatic wait_rst();
        int n;
        n = 0;
        while (drst !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        chk("drive reset", 16'h1, {15'h0, drst});
        step(1);
    endtask
    task automatic pulse(input logic b);
        if (b) press = 1'b1;
        else toggle = 1'b1;
        step(1);
        press = 1'b0;
        toggle = 1'b0;
        wait_rst();
    endtask
    // one trip source with given response bits; a taken trip is cleared by a reset input toggle
    task automatic trip_case(input logic [3:0] bits, input logic f, input logic [3:0] s, input logic e);
        wr_par(`DMST_SEL_TRIP, {12'h0, bits}, 1'b0, 1'b0);
        frame0 = f;
        src = {1'b0, s[2:0]};
        ni = {5'h0, s[3]};
        step(2);
        chk("trip", {15'h0, e}, {15'h0, trip});
        src = 4'h0;
        ni = 6'h00;
        if (e) pulse(1'b0);
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ****************************************************
    // test sequence
    // ****************************************************
    initial begin
        logic [2:0] m;
        logic       usa;
        step(10);
        rst = 1'b0;
        chk("power on mode", 16'h1, {13'h0, mode});
        rd_par(`DMST_SEL_VER, `DMST_FW_VER);
        wr_par(`DMST_SEL_VER, 16'h0005, 1'b0, 1'b1);
        wr_par(`DMST_SEL_MODE, 16'h0002, 1'b0, 1'b1);
        wr_par(`DMST_SEL_UNLOCK, `DMST_KEY_EUR, 1'b0, 1'b0);
        wr_par(`DMST_SEL_MODE, 16'h0000, 1'b0, 1'b1);
        wr_par(`DMST_SEL_MODE, 16'h0005, 1'b1, 1'b1);
        wr_par(`DMST_SEL_TRIP, 16'h0010, 1'b0, 1'b1);
        wr_par(`DMST_SEL_TRIP, 16'h000f, 1'b0, 1'b0);
        rd_par(`DMST_SEL_TRIP, 16'h000f);
        wr_par(`DMST_SEL_SEC, 16'h0003, 1'b0, 1'b1);
        wr_par(`DMST_SEL_SEC, 16'h0001, 1'b0, 1'b0);
        wr_par(`DMST_SEL_KPACC, 16'h0007, 1'b0, 1'b0);
        wr_par(`DMST_SEL_RSTCMD, `DMST_RST_CMD, 1'b0, 1'b0);
        chk("keypad reset", 16'h0, {15'h0, drst});
        // mode changes 2,3,4,1 by serial reset, alternating supply region
        for (int i = 0; i < 4; i++) begin
            m = (i == 3) ? 3'h1 : 3'(i + 2);
            usa = m[0];
            wr_par(`DMST_SEL_UNLOCK, usa ? `DMST_KEY_USA : `DMST_KEY_EUR, 1'b0, 1'b0);
            wr_par(`DMST_SEL_MODE, {13'h0, m}, 1'b1, 1'b0);
            rd_par(`DMST_SEL_MODE, {13'h0, m});
            chk("mode before reset", (i == 0) ? 16'h1 : 16'(i + 1), {13'h0, mode});
            wr_par(`DMST_SEL_RSTCMD, `DMST_RST_CMD, 1'b1, 1'b0);
            wait_rst();
            chk("defaults load", 16'h1, {15'h0, dload});
            chk("motor defaults", 16'h1, {15'h0, mdef});
            chk("nvm save", 16'h1, {15'h0, nsave});
            chk("active mode", {13'h0, m}, {13'h0, mode});
            chk("region", {15'h0, usa}, {15'h0, region});
            rd_par(`DMST_SEL_UNLOCK, 16'h0000);
            rd_par(`DMST_SEL_SEC, 16'h0001);
            rd_par(`DMST_SEL_KPACC, 16'h0007);
            rd_par(`DMST_SEL_TRIP, 16'h0000);
            // stop-before-trip response on a non-important trip, except in regen
            wr_par(`DMST_SEL_TRIP, 16'h0001, 1'b0, 1'b0);
            ni = 6'h10;
            step(2);
            ni = 6'h00;
            chk("regen trip", {15'h0, m == 3'h4}, {15'h0, trip});
            chk("stop request", {15'h0, m != 3'h4}, {15'h0, stop});
            step(6);
            chk("trip after stop", 16'h1, {15'h0, trip});
        end
        pulse(1'b0);
        chk("trip cleared", 16'h0, {15'h0, trip});
        trip_case(4'h0, 1'b0, 4'h8, 1'b1);
        trip_case(4'h2, 1'b0, 4'h1, 1'b0);
        trip_case(4'h0, 1'b0, 4'h1, 1'b1);
        trip_case(4'h4, 1'b1, 4'h2, 1'b0);
        trip_case(4'h4, 1'b0, 4'h2, 1'b1);
        trip_case(4'h8, 1'b1, 4'h4, 1'b0);
        trip_case(4'h8, 1'b0, 4'h4, 1'b1);
        // lock by security 2 and the reset button, then keypad limits
        wr_par(`DMST_SEL_SEC, 16'h0002, 1'b0, 1'b0);
        pulse(1'b1);
        chk("user lock", 16'h1, {15'h0, lock});
        rd_par(`DMST_SEL_SEC, 16'h0000);
        chk("menu 0 only", 16'h0, {15'h0, menu});
        wr_par(`DMST_SEL_TRIP, 16'h0001, 1'b0, 1'b1);
        wr_par(`DMST_SEL_TRIP, 16'h0001, 1'b1, 1'b0);
        wr_par(`DMST_SEL_SEC, 16'h0001, 1'b0, 1'b0);
        step(1);
        chk("all menus", 16'h1, {15'h0, menu});
        give_verdict();
    end
    // watchdog well beyond the roughly 200 cycles the sequence needs
    initial begin
        #50000;
        failures++;
        give_verdict();
    end
endmodule
`default_nettype wire
